// ==== include/spg_cfg.svh ====
`ifndef SPG_CFG_SVH
`define SPG_CFG_SVH
// How it works
// - Sleep mode field: 000 idle, 010 down, 011 save, 110 standby, 111 extended.
// - Idle stops only the CPU and flash clocks; everything else keeps running.
// - Outside idle, both external lines wake the part only as level interrupts.
// - Async domain, timer oscillator and timer-2 wake need the async clock select.
// - The comparator is switched off in every sleep mode except idle.
// - A live comparator using the reference keeps it on in any sleep mode.
// - An enabling brown-out fuse setting keeps the detector on in all modes.
// - The reference is on only while brown-out or comparator needs it.
// - A reference kept on is valid at once; a restarted one waits start-up.
// - An enabled watchdog keeps running in every sleep mode.
// - Digital input buffers are shut while the I/O clock is stopped.
// - A pin needed for wake-up keeps its input logic on during sleep.
// - With debug enabled, the main clock source runs through all sleep.
// - Debug is off if its fuse, the scan fuse is clear, or the disable bit set.

`define SPG_MODE_IDLE   3'b000
`define SPG_MODE_PDOWN  3'b010
`define SPG_MODE_PSAVE  3'b011
`define SPG_MODE_STBY   3'b110
`define SPG_MODE_XSTBY  3'b111

`define SPG_BOD_W       2
`define SPG_BOD_OFF     2'b11

`define SPG_ON          1'b1
`define SPG_OFF         1'b0

`define SPG_CLK_NS      20
`define SPG_VREF_START_NS 70000
`define SPG_VREF_CYC    ((`SPG_VREF_START_NS + `SPG_CLK_NS - 1) / `SPG_CLK_NS)
`endif

// ==== include/spg_mode_if.sv ====
`timescale 1ns/1ns

interface spg_mode_if;
  logic sleeping;
  logic deep;
  logic asy_mode;
  logic main_keep;
  logic reserved;

  modport dec
  (
    output sleeping,
    output deep,
    output asy_mode,
    output main_keep,
    output reserved
  );

  modport use_side
  (
    input sleeping,
    input deep,
    input asy_mode,
    input main_keep,
    input reserved
  );
endinterface

// ==== include/spg_pkg.sv ====
`include "spg_cfg.svh"

package spg_pkg;

  typedef enum logic [2:0] {
    SPG_IDLE  = `SPG_MODE_IDLE,
    SPG_PDOWN = `SPG_MODE_PDOWN,
    SPG_PSAVE = `SPG_MODE_PSAVE,
    SPG_STBY  = `SPG_MODE_STBY,
    SPG_XSTBY = `SPG_MODE_XSTBY
  } spg_mode_e;

  typedef logic [`SPG_BOD_W-1:0] spg_bod_t;

endpackage

// ==== rtl/spg_mode_decode.sv ====
`timescale 1ns/1ns

module spg_mode_decode
  import spg_pkg::*;
(
  input  wire logic       sleep_i,
  input  wire logic [2:0] sleep_mode_select_i,
  spg_mode_if.dec         mode
);
  import spg_pkg::*;

  always_comb
  begin
    mode.sleeping  = sleep_i;
    mode.deep      = 1'b0;
    mode.asy_mode  = 1'b0;
    mode.main_keep = 1'b0;
    mode.reserved  = 1'b0;
    unique case (sleep_mode_select_i)
      SPG_IDLE:  mode.main_keep = 1'b1;
      SPG_PDOWN: mode.deep      = sleep_i;
      SPG_PSAVE:
      begin
        mode.deep     = sleep_i;
        mode.asy_mode = 1'b1;
      end
      SPG_STBY:
      begin
        mode.deep      = sleep_i;
        mode.main_keep = 1'b1;
      end
      SPG_XSTBY:
      begin
        mode.deep      = sleep_i;
        mode.asy_mode  = 1'b1;
        mode.main_keep = 1'b1;
      end
      // Reserved codes behave as idle so nothing is gated by mistake
      default:
      begin
        mode.main_keep = 1'b1;
        mode.reserved  = 1'b1;
      end
    endcase
  end

endmodule // spg_mode_decode

// ==== rtl/spg_top.sv ====
`timescale 1ns/1ns

`include "spg_cfg.svh"

module spg_top
  import spg_pkg::*;
#(
  parameter int NPIN      = 8,
  parameter int VREF_CYC  = `SPG_VREF_CYC
)
(
  input  wire logic            clk_i,
  input  wire logic            rstn_i,
  input  wire logic            sleep_i,
  input  wire logic [2:0]      sleep_mode_select_i,
  input  wire logic            async_timer_clock_select_i,
  input  wire logic            comp_disable_i,
  input  wire logic            comp_use_vref_i,
  input  wire spg_pkg::spg_bod_t brownout_level_fuse_i,
  input  wire logic            watchdog_enable_i,
  input  wire logic            debug_enable_fuse_i,
  input  wire logic            scan_port_enable_fuse_i,
  input  wire logic            debug_port_disable_bit_i,
  input  wire logic [1:0]      ext_irq_sense_level_i,
  input  wire logic [NPIN-1:0] wake_pin_need_i,
  output logic                 cpu_clk_en_o,
  output logic                 flash_clk_en_o,
  output logic                 io_clk_en_o,
  output logic                 asy_clk_en_o,
  output logic                 timer_osc_en_o,
  output logic                 main_clk_en_o,
  output logic                 comp_en_o,
  output logic                 bod_en_o,
  output logic                 wdt_en_o,
  output logic                 vref_en_o,
  output logic                 vref_valid_o,
  output logic                 debug_en_o,
  output logic [1:0]           ext_irq_wake_en_o,
  output logic                 timer2_wake_en_o,
  output logic [NPIN-1:0]      input_buf_en_o,
  output logic                 mode_reserved_o
);
  import spg_pkg::*;

  initial
  begin
    if (NPIN < 1)
      $error("spg_top: NPIN must be at least 1");
    if (VREF_CYC < 2)
      $error("spg_top: VREF_CYC must be at least 2");
  end

  spg_mode_if mode ();

  spg_mode_decode u_decode (
    .sleep_i             (sleep_i),
    .sleep_mode_select_i (sleep_mode_select_i),
    .mode                (mode)
  );

  logic            next_cpu_clk;
  logic            next_flash_clk;
  logic            next_io_clk;
  logic            next_asy_clk;
  logic            next_timer_osc;
  logic            next_main_clk;
  logic            next_comp;
  logic            next_bod;
  logic            next_wdt;
  logic            next_debug;
  logic [1:0]      next_ext_wake;
  logic            next_t2_wake;
  logic            next_reserved;
  logic [NPIN-1:0] next_buf;
  logic            vref_need;
  logic            asy_live;

  always_comb
  begin
    next_cpu_clk   = !mode.sleeping;
    next_flash_clk = !mode.sleeping;
    next_io_clk    = !mode.deep;
    asy_live       = !mode.deep || (mode.asy_mode && async_timer_clock_select_i);
    next_asy_clk   = asy_live && async_timer_clock_select_i;
    next_timer_osc = asy_live && async_timer_clock_select_i;
    next_t2_wake   = mode.sleeping && asy_live && async_timer_clock_select_i;
    next_debug     = debug_enable_fuse_i && scan_port_enable_fuse_i
                     && !debug_port_disable_bit_i;
    // Debug keeps the main source alive even in the deepest modes
    next_main_clk  = !mode.deep || mode.main_keep || next_debug;
    // Relies on software for the idle case; the hardware gate covers the rest
    next_comp      = !comp_disable_i && !mode.deep;
    next_bod       = brownout_level_fuse_i != `SPG_BOD_OFF;
    next_wdt       = watchdog_enable_i;
    // Comparator demand ignores the sleep gate when it uses the reference
    vref_need      = next_bod || (comp_use_vref_i && !comp_disable_i);
    next_reserved  = mode.reserved;
    for (int i = 0; i < 2; i++)
    begin
      // Edge sensing needs the I/O clock, so deep sleep accepts levels only
      next_ext_wake[i] = !mode.deep || ext_irq_sense_level_i[i];
    end
  end

  genvar g;
  generate
    for (g = 0; g < NPIN; g++)
    begin : g_pin
      always_comb
      begin
        next_buf[g] = !mode.deep || wake_pin_need_i[g];
      end

      always_ff @(posedge clk_i or negedge rstn_i)
      begin
        if (!rstn_i)
          input_buf_en_o[g] <= `SPG_ON;
        else
          input_buf_en_o[g] <= next_buf[g];
      end

      a_buf_gating: assert property (@(posedge clk_i) disable iff (!rstn_i)
        sleep_i && !wake_pin_need_i[g] && (sleep_mode_select_i == `SPG_MODE_PDOWN)
        |=> !input_buf_en_o[g]) else $error("input buffer left on in deep sleep");

      a_buf_wake_pin: assert property (@(posedge clk_i) disable iff (!rstn_i)
        wake_pin_need_i[g] |=> input_buf_en_o[g])
        else $error("wake pin buffer shut");
    end
  endgenerate

  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      cpu_clk_en_o      <= `SPG_ON;
      flash_clk_en_o    <= `SPG_ON;
      io_clk_en_o       <= `SPG_ON;
      asy_clk_en_o      <= `SPG_OFF;
      timer_osc_en_o    <= `SPG_OFF;
      main_clk_en_o     <= `SPG_ON;
      comp_en_o         <= `SPG_OFF;
      bod_en_o          <= `SPG_OFF;
      wdt_en_o          <= `SPG_OFF;
      debug_en_o        <= `SPG_OFF;
      ext_irq_wake_en_o <= '0;
      timer2_wake_en_o  <= `SPG_OFF;
      mode_reserved_o   <= `SPG_OFF;
    end
    else
    begin
      cpu_clk_en_o      <= next_cpu_clk;
      flash_clk_en_o    <= next_flash_clk;
      io_clk_en_o       <= next_io_clk;
      asy_clk_en_o      <= next_asy_clk;
      timer_osc_en_o    <= next_timer_osc;
      main_clk_en_o     <= next_main_clk;
      comp_en_o         <= next_comp;
      bod_en_o          <= next_bod;
      wdt_en_o          <= next_wdt;
      debug_en_o        <= next_debug;
      ext_irq_wake_en_o <= next_ext_wake;
      timer2_wake_en_o  <= next_t2_wake;
      mode_reserved_o   <= next_reserved;
    end
  end

  spg_vref_ctrl #(
    .START_CYC (VREF_CYC)
  ) u_vref (
    .clk_i   (clk_i),
    .rstn_i  (rstn_i),
    .need_i  (vref_need),
    .en_o    (vref_en_o),
    .valid_o (vref_valid_o)
  );

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!rstn_i);

  a_mode_reserved: assert property (
    (sleep_mode_select_i == 3'b001 || sleep_mode_select_i == 3'b100
     || sleep_mode_select_i == 3'b101) |=> mode_reserved_o && !flash_clk_en_o == $past(sleep_i))
    else $error("reserved sleep code not flagged");

  a_idle_clocks: assert property (
    sleep_i && sleep_mode_select_i == `SPG_MODE_IDLE
    |=> !cpu_clk_en_o && !flash_clk_en_o && io_clk_en_o && main_clk_en_o)
    else $error("idle gated the wrong clocks");

  a_level_wake: assert property (
    sleep_i && sleep_mode_select_i == `SPG_MODE_PSAVE && !ext_irq_sense_level_i[1]
    |=> !ext_irq_wake_en_o[1]) else $error("edge wake allowed in deep sleep");

  a_asy_gate: assert property (
    !async_timer_clock_select_i |=> !asy_clk_en_o && !timer_osc_en_o && !timer2_wake_en_o)
    else $error("async domain on without select");

  a_asy_save: assert property (
    sleep_i && async_timer_clock_select_i && sleep_mode_select_i == `SPG_MODE_XSTBY
    |=> asy_clk_en_o && timer2_wake_en_o && main_clk_en_o)
    else $error("async domain lost in extended standby");

  a_comp_sleep: assert property (
    sleep_i && (sleep_mode_select_i inside {`SPG_MODE_PDOWN, `SPG_MODE_PSAVE,
    `SPG_MODE_STBY, `SPG_MODE_XSTBY}) |=> !comp_en_o)
    else $error("comparator on in deep sleep");

  a_vref_keep: assert property (
    comp_use_vref_i && !comp_disable_i ##1 comp_use_vref_i && !comp_disable_i
    |-> vref_en_o) else $error("reference dropped for comparator");

  a_bod_keep: assert property (
    brownout_level_fuse_i != `SPG_BOD_OFF |=> bod_en_o && vref_en_o)
    else $error("brown-out detector off while fused on");

  a_vref_idle: assert property (
    brownout_level_fuse_i == `SPG_BOD_OFF && (comp_disable_i || !comp_use_vref_i)
    |=> !vref_en_o && !vref_valid_o) else $error("reference on with no user");

  a_wdt_keep: assert property (
    watchdog_enable_i |=> wdt_en_o) else $error("watchdog stopped in sleep");

  a_main_debug: assert property (
    debug_enable_fuse_i && scan_port_enable_fuse_i && !debug_port_disable_bit_i
    |=> main_clk_en_o && debug_en_o) else $error("main clock stopped under debug");

  a_debug_off: assert property (
    !debug_enable_fuse_i || !scan_port_enable_fuse_i || debug_port_disable_bit_i
    |=> !debug_en_o) else $error("debug left enabled");

  a_reg_latency: assert property (
    $changed(watchdog_enable_i) |-> wdt_en_o != watchdog_enable_i ##1
    wdt_en_o == $past(watchdog_enable_i)) else $error("enable not registered once");

endmodule // spg_top

// ==== rtl/spg_vref_ctrl.sv ====
`timescale 1ns/1ns

`include "spg_cfg.svh"

module spg_vref_ctrl #(
  parameter int START_CYC = `SPG_VREF_CYC
)
(
  input  wire logic clk_i,
  input  wire logic rstn_i,
  input  wire logic need_i,
  output logic      en_o,
  output logic      valid_o
);
  import spg_pkg::*;

  localparam int CW = $clog2(START_CYC + 1);

  initial
  begin
    // One cycle would raise valid together with the enable, skipping start-up
    if (START_CYC < 2)
      $error("spg_vref_ctrl: START_CYC must be at least 2");
  end

  logic          next_en;
  logic          next_valid;
  logic [CW-1:0] cnt;
  logic [CW-1:0] next_cnt;

  always_comb
  begin
    next_en    = need_i;
    next_cnt   = cnt;
    next_valid = valid_o;
    if (!need_i)
    begin
      next_cnt   = '0;
      next_valid = `SPG_OFF;
    end
    else if (!valid_o)
    begin
      // Start-up counted only from a fresh enable; staying on keeps valid
      if (cnt == CW'(START_CYC - 1))
        next_valid = `SPG_ON;
      else
        next_cnt = cnt + CW'(1);
    end
  end

  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      en_o    <= `SPG_OFF;
      valid_o <= `SPG_OFF;
      cnt     <= '0;
    end
    else
    begin
      en_o    <= next_en;
      valid_o <= next_valid;
      cnt     <= next_cnt;
    end
  end

  a_vref_valid_off: assert property (@(posedge clk_i) disable iff (!rstn_i)
    valid_o |-> en_o) else $error("reference valid while disabled");

  a_vref_start_wait: assert property (@(posedge clk_i) disable iff (!rstn_i)
    $rose(en_o) |-> !valid_o) else $error("reference valid without start-up");

endmodule // spg_vref_ctrl

// ==== verification/spg_soft_model.sv ====
`timescale 1ns/1ns

module spg_soft_model
(
  input  wire logic comp_needed_i,
  input  wire logic vref_en_i,
  input  wire logic vref_valid_i,
  output logic      comp_disable_o,
  output logic      ref_usable_o
);
  // Software shuts the comparator when unused, idle included
  assign comp_disable_o = !comp_needed_i;
  // Reference read only once started, never on enable alone
  assign ref_usable_o = vref_en_i && vref_valid_i;
endmodule // spg_soft_model

// ==== verification/tb_top.sv ====
`timescale 1ns/1ns

module tb_top;
  import spg_pkg::*;
  localparam int            NP     = 8;
  localparam int            VC     = 4;
  localparam logic [3:0]    C_NEED = 4'b0101;
  localparam logic [3:0]    C_USE  = 4'b1011;
  localparam logic [7:0]    C_FUSE = 8'b11_00_10_11;
  localparam logic [3:0]    C_WDE  = 4'b0101;
  localparam logic [3:0]    C_DBG  = 4'b0111;
  localparam logic [3:0]    C_SCAN = 4'b1101;
  localparam logic [3:0]    C_JTD  = 4'b0100;
  localparam logic [7:0]    C_LVL  = 8'b00_11_10_01;
  localparam logic [31:0]   C_PIN  = 32'h3cff0081;
  logic                     clk_i, rstn_i, sleep_i, async_sel, comp_need, use_vref;
  logic                     wde, dbg_fuse, scan_fuse, dis_bit, comp_dis, ref_ok;
  logic [2:0]               mode;
  spg_bod_t                 fuse;
  logic [1:0]               level, ext_en;
  logic [NP-1:0]            need, buf_en;
  logic                     cpu_en, flash_en, io_en, asy_en, tosc_en, main_en, comp_en;
  logic                     bod_en, wdt_en, vref_en, vref_ok, dbg_en, t2_en, resv;
  int                       bad_count, checks, cyc;

  spg_top #(.NPIN(NP), .VREF_CYC(VC)) i_dut
  (
    .clk_i(clk_i), .rstn_i(rstn_i), .sleep_i(sleep_i), .sleep_mode_select_i(mode),
    .async_timer_clock_select_i(async_sel), .comp_disable_i(comp_dis),
    .comp_use_vref_i(use_vref), .brownout_level_fuse_i(fuse), .watchdog_enable_i(wde),
    .debug_enable_fuse_i(dbg_fuse), .scan_port_enable_fuse_i(scan_fuse),
    .debug_port_disable_bit_i(dis_bit), .ext_irq_sense_level_i(level),
    .wake_pin_need_i(need), .cpu_clk_en_o(cpu_en), .flash_clk_en_o(flash_en),
    .io_clk_en_o(io_en), .asy_clk_en_o(asy_en), .timer_osc_en_o(tosc_en),
    .main_clk_en_o(main_en), .comp_en_o(comp_en), .bod_en_o(bod_en), .wdt_en_o(wdt_en),
    .vref_en_o(vref_en), .vref_valid_o(vref_ok), .debug_en_o(dbg_en),
    .ext_irq_wake_en_o(ext_en), .timer2_wake_en_o(t2_en), .input_buf_en_o(buf_en),
    .mode_reserved_o(resv)
  );

  spg_soft_model i_soft
  (
    .comp_needed_i(comp_need), .vref_en_i(vref_en), .vref_valid_i(vref_ok),
    .comp_disable_o(comp_dis), .ref_usable_o(ref_ok)
  );

  initial
  begin
    clk_i = 1'b0;
    forever #10 clk_i = ~clk_i;
  end

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  always @(posedge clk_i)
  begin
    cyc <= cyc + 1;
    // Whole run needs about 300 cycles
    if (cyc == 2000)
    begin
      bad_count++;
      report_and_stop();
    end
  end

  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic drive(input logic s, input logic [2:0] m, input logic a, input int k);
    @(posedge clk_i);
    sleep_i   <= s;
    mode      <= m;
    async_sel <= a;
    comp_need <= C_NEED[k];
    use_vref  <= C_USE[k];
    fuse      <= C_FUSE[2*k +: 2];
    wde       <= C_WDE[k];
    dbg_fuse  <= C_DBG[k];
    scan_fuse <= C_SCAN[k];
    dis_bit   <= C_JTD[k];
    level     <= C_LVL[2*k +: 2];
    need      <= C_PIN[8*k +: 8];
  endtask

  task automatic expect_all();
    logic deep;
    logic de;
    logic asy;
    @(posedge clk_i);
    @(negedge clk_i);
    deep = sleep_i && (mode inside {3'b010, 3'b011, 3'b110, 3'b111});
    de   = dbg_fuse && scan_fuse && !dis_bit;
    asy  = async_sel && (!deep || mode inside {3'b011, 3'b111});
    check("cpu_clk", 16'(cpu_en), 16'(!sleep_i));
    check("flash_clk", 16'(flash_en), 16'(!sleep_i));
    check("io_clk", 16'(io_en), 16'(!deep));
    check("asy_clk", 16'(asy_en), 16'(asy));
    check("timer_osc", 16'(tosc_en), 16'(asy));
    check("timer2_wake", 16'(t2_en), 16'(asy && sleep_i));
    check("main_clk", 16'(main_en), 16'(!deep || mode[2:1] == 2'b11 || de));
    check("comp", 16'(comp_en), 16'(comp_need && !deep));
    check("bod", 16'(bod_en), 16'(fuse !== 2'b11));
    check("wdt", 16'(wdt_en), 16'(wde));
    check("vref_en", 16'(vref_en), 16'(fuse !== 2'b11 || (use_vref && comp_need)));
    check("debug", 16'(dbg_en), 16'(de));
    check("ext_wake", 16'(ext_en), 16'({2{!deep}} | level));
    check("in_buf", 16'(buf_en), 16'({NP{!deep}} | need));
    if (sleep_i)
      check("reserved", 16'(resv), 16'(mode inside {3'b001, 3'b100, 3'b101}));
  endtask

  initial
  begin
    {rstn_i, sleep_i, async_sel, comp_need, use_vref, wde, dbg_fuse} = '0;
    {scan_fuse, dis_bit, mode, level, need, bad_count, checks} = '0;
    fuse = 2'b11;
    repeat (5) @(posedge clk_i);
    @(negedge clk_i);
    check("rst io_clk", 16'(io_en), 16'h0001);
    check("rst in_buf", 16'(buf_en), 16'h00ff);
    check("rst vref_ok", 16'(vref_ok), 16'h0000);
    @(posedge clk_i);
    rstn_i <= 1'b1;
    $display("test reset done");
    for (int i = 0; i < 128; i++)
    begin
      drive(i[3], i[2:0], i[4], i >> 5);
      expect_all();
    end
    $display("test mode table done");
    drive(1'b0, 3'b000, 1'b0, 3);
    repeat (VC + 2) @(posedge clk_i);
    comp_need <= 1'b1;
    repeat (VC - 1) @(posedge clk_i);
    @(negedge clk_i);
    check("vref_ok early", 16'(vref_ok), 16'h0000);
    @(negedge clk_i);
    check("vref_ok started", 16'(vref_ok), 16'h0001);
    check("ref usable", 16'(ref_ok), 16'h0001);
    @(posedge clk_i);
    sleep_i <= 1'b1;
    mode    <= 3'b010;
    repeat (2) @(negedge clk_i);
    check("vref kept", 16'({vref_en, vref_ok}), 16'h0003);
    check("comp deep", 16'(comp_en), 16'h0000);
    @(posedge clk_i);
    comp_need <= 1'b0;
    repeat (2) @(negedge clk_i);
    check("vref off", 16'({vref_en, vref_ok}), 16'h0000);
    $display("test reference done");
    @(posedge clk_i);
    rstn_i <= 1'b0;
    @(negedge clk_i);
    check("mid rst main", 16'({main_en, comp_en}), 16'h0002);
    @(posedge clk_i);
    rstn_i <= 1'b1;
    drive(1'b1, 3'b110, 1'b1, 0);
    expect_all();
    $display("test second reset done");
    report_and_stop();
  end
endmodule // tb_top
